/* common/sync_ctrl_pkg.sv */
// Constants shared by the channel start and frequency-hop synchronisation logic
package sync_ctrl_pkg;
    // External (direct) register addresses
    localparam logic [7:0] ADDR_SLEEP     = 8'h03;
    localparam logic [7:0] ADDR_PIN_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_SOFT_CTRL = 8'h05;
    localparam logic [7:0] ADDR_STATUS    = 8'h06;
    // Per-channel internal register addresses
    localparam logic [7:0] ADDR_START_CNT = 8'h83;
    localparam logic [7:0] ADDR_FREQ_CNT  = 8'h84;
    localparam logic [7:0] ADDR_FREQ      = 8'h85;
    localparam logic [7:0] ADDR_PIN_SEL   = 8'h86;
    // Address bit that selects the internal per-channel space
    localparam int INTERNAL_BIT   = 7;
    // Field positions in pin and soft control registers
    localparam int PIN_START_BIT  = 4;
    localparam int PIN_HOP_BIT    = 5;
    localparam int SOFT_START_BIT = 4;
    localparam int SOFT_HOP_BIT   = 5;
    localparam int PIN_SEL_W      = 2;
    localparam int PIN_EN_LSB     = 0;
    localparam int SOFT_CHAN_LSB  = 0;
    // Reset values
    localparam logic [3:0] SLEEP_RST = 4'hf;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    // Latency figures in master clocks
    localparam int START_SOFT_EXTRA = 6;
    localparam int START_PIN_EXTRA  = 3;
    localparam int HOP_SOFT_EXTRA   = 7;
    localparam int HOP_PIN_EXTRA    = 5;
    // Pipeline depths derived from the latency figures
    localparam int RUN_PIPE       = START_PIN_EXTRA - 1;
    localparam int FREQ_PIPE      = HOP_PIN_EXTRA - 1;
    localparam int SOFT_START_DLY = START_SOFT_EXTRA - RUN_PIPE;
    localparam int SOFT_HOP_DLY   = HOP_SOFT_EXTRA - FREQ_PIPE;
endpackage

/* common/holdoff_if.sv */
// Trigger, count and completion signals of one hold-off counter
`timescale 1ns/1ns
`default_nettype none
interface holdoff_if #(
    parameter int CNT_W = 16
);
    logic             trig;
    logic [CNT_W-1:0] count;
    logic             fire;
    logic             busy;

    modport counter (input trig, input count, output fire, output busy);
    modport owner   (output trig, output count, input fire, input busy);
endinterface
`default_nettype wire

/* src/holdoff_counter.sv */
// One hold-off down-counter that fires once after the last trigger; a trigger while counting reloads the count
`timescale 1ns/1ns
`default_nettype none
module holdoff_counter #(
    parameter int CNT_W = 16
) (
    input  wire logic   clk_in,
    input  wire logic   rstn_in,
    holdoff_if.counter  hif
);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic [CNT_W-1:0] cnt_reg;
    logic             busy_reg;

    // Count zero or one fires on the next cycle, so a trigger never hangs
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
        end else if (hif.trig) begin
            cnt_reg  <= (hif.count <= CNT_ONE) ? CNT_ONE : hif.count;
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            if (cnt_reg == CNT_ONE) begin
                busy_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - CNT_ONE;
            end
        end
    end

    // Completion in the cycle the count stands at one
    assign hif.fire = busy_reg && (cnt_reg == CNT_ONE);
    assign hif.busy = busy_reg;
endmodule
`default_nettype wire

/* src/channel_start_hop_sync.sv */
// Start and frequency-hop synchroniser for four receive channels
`timescale 1ns/1ns
`default_nettype none
module channel_start_hop_sync #(
    parameter int NUM_CHAN = 4,
    parameter int CNT_W    = 16,
    parameter int FREQ_W   = 32,
    parameter int DATA_W   = 32
) (
    input  wire logic                     clk_in,
    input  wire logic                     rstn_in,
    input  wire logic [7:0]               addr_in,
    input  wire logic [1:0]               chan_in,
    input  wire logic [DATA_W-1:0]        wdata_in,
    input  wire logic                     wr_in,
    input  wire logic                     rd_in,
    input  wire logic [3:0]               sync_pin_in,
    output logic      [DATA_W-1:0]        rdata_out,
    output logic                          rdy_out,
    output logic      [NUM_CHAN-1:0]      chan_run_out,
    output logic      [NUM_CHAN*FREQ_W-1:0] osc_freq_out
);
    localparam int SS_DLY = sync_ctrl_pkg::SOFT_START_DLY;
    localparam int SH_DLY = sync_ctrl_pkg::SOFT_HOP_DLY;
    localparam int R_PIPE = sync_ctrl_pkg::RUN_PIPE;
    localparam int F_PIPE = sync_ctrl_pkg::FREQ_PIPE;
    localparam int PSEL_W = sync_ctrl_pkg::PIN_SEL_W;

    // Host-visible state
    logic [NUM_CHAN-1:0] sleep_reg;
    logic [7:0]          pin_ctrl_reg;
    logic [7:0]          soft_ctrl_reg;
    logic [CNT_W-1:0]    start_cnt_reg   [NUM_CHAN];
    logic [CNT_W-1:0]    freq_cnt_reg    [NUM_CHAN];
    logic [FREQ_W-1:0]   shadow_freq_reg [NUM_CHAN];
    logic [FREQ_W-1:0]   active_freq_reg [NUM_CHAN];
    logic [PSEL_W-1:0]   pin_sel_reg     [NUM_CHAN];

    // Port answer
    logic [DATA_W-1:0]   rdata_reg;
    logic [DATA_W-1:0]   rdata_next;
    logic                rdy_reg;

    // Trigger and latency-matching pipelines
    logic [3:0]          pin_prev_reg;
    logic [NUM_CHAN-1:0] soft_start_pipe_reg [SS_DLY];
    logic [NUM_CHAN-1:0] soft_hop_pipe_reg   [SH_DLY];
    logic [NUM_CHAN-1:0] run_pipe_reg        [R_PIPE];
    logic [FREQ_W-1:0]   freq_pipe_reg       [F_PIPE][NUM_CHAN];

    // Decode and trigger terms
    logic                is_internal;
    logic                wr_sleep;
    logic                wr_pin_ctrl;
    logic                wr_soft_ctrl;
    logic                wr_start_cnt;
    logic                wr_freq_cnt;
    logic                wr_freq;
    logic                wr_pin_sel;
    logic [3:0]          pin_rise;
    logic [NUM_CHAN-1:0] soft_start_now;
    logic [NUM_CHAN-1:0] soft_hop_now;
    logic [NUM_CHAN-1:0] pin_hit;
    logic [NUM_CHAN-1:0] start_trig;
    logic [NUM_CHAN-1:0] hop_trig;
    logic [NUM_CHAN-1:0] start_fire;
    logic [NUM_CHAN-1:0] hop_fire;
    logic [NUM_CHAN-1:0] start_busy;
    logic [NUM_CHAN-1:0] hop_busy;

    // Control fields and channel select
    logic [3:0]          pin_enable;
    logic                start_on_pin;
    logic                hop_on_pin;
    logic [NUM_CHAN-1:0] soft_chan;
    logic                soft_start_req;
    logic                soft_hop_req;
    logic [NUM_CHAN-1:0] chan_sel;

    // Countdown status as the host reads it
    logic [2*NUM_CHAN-1:0] status_word;

    // Write decode; internal registers are reached through the channel index
    assign is_internal  = addr_in[sync_ctrl_pkg::INTERNAL_BIT];
    assign wr_sleep     = wr_in && (addr_in == sync_ctrl_pkg::ADDR_SLEEP);
    assign wr_pin_ctrl  = wr_in && (addr_in == sync_ctrl_pkg::ADDR_PIN_CTRL);
    assign wr_soft_ctrl = wr_in && (addr_in == sync_ctrl_pkg::ADDR_SOFT_CTRL);
    assign wr_start_cnt = wr_in && (addr_in == sync_ctrl_pkg::ADDR_START_CNT);
    assign wr_freq_cnt  = wr_in && (addr_in == sync_ctrl_pkg::ADDR_FREQ_CNT);
    assign wr_freq      = wr_in && (addr_in == sync_ctrl_pkg::ADDR_FREQ);
    assign wr_pin_sel   = wr_in && (addr_in == sync_ctrl_pkg::ADDR_PIN_SEL);

    // Rising edge of each pin; a pin held high triggers only once
    assign pin_rise = sync_pin_in & ~pin_prev_reg;

    // Named control fields; soft triggers act only in the cycle of the write
    assign pin_enable     = pin_ctrl_reg[sync_ctrl_pkg::PIN_EN_LSB +: 4];
    assign start_on_pin   = pin_ctrl_reg[sync_ctrl_pkg::PIN_START_BIT];
    assign hop_on_pin     = pin_ctrl_reg[sync_ctrl_pkg::PIN_HOP_BIT];
    assign soft_chan      = wdata_in[sync_ctrl_pkg::SOFT_CHAN_LSB +: NUM_CHAN];
    assign soft_start_req = wr_soft_ctrl && wdata_in[sync_ctrl_pkg::SOFT_START_BIT];
    assign soft_hop_req   = wr_soft_ctrl && wdata_in[sync_ctrl_pkg::SOFT_HOP_BIT];
    assign status_word    = {hop_busy, start_busy};

    // One-hot channel select; an index beyond the channel count selects nothing
    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            chan_sel[c] = (int'(chan_in) == c);
        end
    end

    // Software triggers name their channels in the same write
    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            soft_start_now[c] = soft_start_req && soft_chan[c];
            soft_hop_now[c]   = soft_hop_req && soft_chan[c];
        end
    end

    // Per-channel trigger sources
    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            // Selected pin must also be enabled in the pin control register
            pin_hit[c]    = pin_enable[pin_sel_reg[c]] && pin_rise[pin_sel_reg[c]];
            start_trig[c] = soft_start_pipe_reg[SS_DLY-1][c]
                            || (start_on_pin && pin_hit[c]);
            hop_trig[c]   = soft_hop_pipe_reg[SH_DLY-1][c]
                            || (hop_on_pin && pin_hit[c]);
        end
    end

    // Two hold-off counters per channel
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        holdoff_if #(.CNT_W(CNT_W)) start_if ();
        holdoff_if #(.CNT_W(CNT_W)) hop_if ();

        assign start_if.trig  = start_trig[c];
        assign start_if.count = start_cnt_reg[c];
        assign hop_if.trig    = hop_trig[c];
        assign hop_if.count   = freq_cnt_reg[c];
        assign start_fire[c]  = start_if.fire;
        assign start_busy[c]  = start_if.busy;
        assign hop_fire[c]    = hop_if.fire;
        assign hop_busy[c]    = hop_if.busy;

        holdoff_counter #(.CNT_W(CNT_W)) u_start_cnt (
            .clk_in  (clk_in),
            .rstn_in (rstn_in),
            .hif     (start_if)
        );

        holdoff_counter #(.CNT_W(CNT_W)) u_hop_cnt (
            .clk_in  (clk_in),
            .rstn_in (rstn_in),
            .hif     (hop_if)
        );
    end

    // Sleep bits: host writes, countdown completion clears
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sleep_reg <= sync_ctrl_pkg::SLEEP_RST;
        end else begin
            if (wr_sleep) begin
                sleep_reg <= wdata_in[NUM_CHAN-1:0];
            end
            // Completion is applied after the write so the event is never lost
            for (int c = 0; c < NUM_CHAN; c++) begin
                if (start_fire[c]) begin
                    sleep_reg[c] <= 1'b0;
                end
            end
        end
    end

    // Pin and soft control registers
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_ctrl_reg  <= sync_ctrl_pkg::CTRL_RST;
            soft_ctrl_reg <= sync_ctrl_pkg::CTRL_RST;
        end else begin
            if (wr_pin_ctrl) begin
                pin_ctrl_reg <= wdata_in[7:0];
            end
            if (wr_soft_ctrl) begin
                soft_ctrl_reg <= wdata_in[7:0];
            end
        end
    end

    // Per-channel hold-off counts and pin selection
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                start_cnt_reg[c] <= '0;
                freq_cnt_reg[c]  <= '0;
                pin_sel_reg[c]   <= '0;
            end
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                if (wr_start_cnt && chan_sel[c]) begin
                    start_cnt_reg[c] <= wdata_in[CNT_W-1:0];
                end
                if (wr_freq_cnt && chan_sel[c]) begin
                    freq_cnt_reg[c] <= wdata_in[CNT_W-1:0];
                end
                if (wr_pin_sel && chan_sel[c]) begin
                    pin_sel_reg[c] <= wdata_in[PSEL_W-1:0];
                end
            end
        end
    end

    // Shadow and active oscillator frequency
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                shadow_freq_reg[c] <= '0;
                active_freq_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                if (hop_fire[c]) begin
                    active_freq_reg[c] <= shadow_freq_reg[c];
                end
            end
            for (int c = 0; c < NUM_CHAN; c++) begin
                if (wr_freq && chan_sel[c]) begin
                    shadow_freq_reg[c] <= wdata_in[FREQ_W-1:0];
                    // Zero count means no synchronisation: the write goes straight through
                    if (freq_cnt_reg[c] == '0) begin
                        active_freq_reg[c] <= wdata_in[FREQ_W-1:0];
                    end
                end
            end
        end
    end

    // Sync pin history for edge detection
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_prev_reg <= 4'h0;
        end else begin
            pin_prev_reg <= sync_pin_in;
        end
    end

    // Soft triggers are delayed so ready-to-effect matches the fixed latency
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < SS_DLY; i++) begin
                soft_start_pipe_reg[i] <= '0;
            end
            for (int i = 0; i < SH_DLY; i++) begin
                soft_hop_pipe_reg[i] <= '0;
            end
        end else begin
            soft_start_pipe_reg[0] <= soft_start_now;
            for (int i = 1; i < SS_DLY; i++) begin
                soft_start_pipe_reg[i] <= soft_start_pipe_reg[i-1];
            end
            soft_hop_pipe_reg[0] <= soft_hop_now;
            for (int i = 1; i < SH_DLY; i++) begin
                soft_hop_pipe_reg[i] <= soft_hop_pipe_reg[i-1];
            end
        end
    end

    // Run enable pipeline models datapath start-up latency
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < R_PIPE; i++) begin
                run_pipe_reg[i] <= '0;
            end
        end else begin
            run_pipe_reg[0] <= ~sleep_reg;
            for (int i = 1; i < R_PIPE; i++) begin
                run_pipe_reg[i] <= run_pipe_reg[i-1];
            end
        end
    end

    // Frequency pipeline models the oscillator load latency
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < F_PIPE; i++) begin
                for (int c = 0; c < NUM_CHAN; c++) begin
                    freq_pipe_reg[i][c] <= '0;
                end
            end
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                freq_pipe_reg[0][c] <= active_freq_reg[c];
                for (int i = 1; i < F_PIPE; i++) begin
                    freq_pipe_reg[i][c] <= freq_pipe_reg[i-1][c];
                end
            end
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rdata_next = '0;
        if (is_internal) begin
            unique case (addr_in)
                sync_ctrl_pkg::ADDR_START_CNT: rdata_next[CNT_W-1:0]  = start_cnt_reg[chan_in];
                sync_ctrl_pkg::ADDR_FREQ_CNT:  rdata_next[CNT_W-1:0]  = freq_cnt_reg[chan_in];
                sync_ctrl_pkg::ADDR_FREQ:      rdata_next[FREQ_W-1:0] = shadow_freq_reg[chan_in];
                sync_ctrl_pkg::ADDR_PIN_SEL:   rdata_next[PSEL_W-1:0] = pin_sel_reg[chan_in];
                default:                       rdata_next = '0;
            endcase
        end else begin
            unique case (addr_in)
                sync_ctrl_pkg::ADDR_SLEEP:     rdata_next[NUM_CHAN-1:0] = sleep_reg;
                sync_ctrl_pkg::ADDR_PIN_CTRL:  rdata_next[7:0] = pin_ctrl_reg;
                sync_ctrl_pkg::ADDR_SOFT_CTRL: rdata_next[7:0] = soft_ctrl_reg;
                // Live countdown state lets software poll for completion
                sync_ctrl_pkg::ADDR_STATUS:    rdata_next[2*NUM_CHAN-1:0] = status_word;
                default:                       rdata_next = '0;
            endcase
        end
    end

    // Port answer: data and ready one cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_reg <= '0;
            rdy_reg   <= 1'b0;
        end else begin
            rdy_reg <= wr_in || rd_in;
            if (rd_in) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // Outputs straight from flip-flops
    assign rdata_out    = rdata_reg;
    assign rdy_out      = rdy_reg;
    assign chan_run_out = run_pipe_reg[R_PIPE-1];
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_freq_out
        assign osc_freq_out[c*FREQ_W +: FREQ_W] = freq_pipe_reg[F_PIPE-1][c];
    end
endmodule
`default_nettype wire

/* sim/sync_monitor.sv */
// Port-level assertions for the channel start and hop synchroniser
`timescale 1ns/1ns
`default_nettype none
module sync_monitor #(
    parameter int NUM_CHAN = 4,
    parameter int CNT_W    = 16,
    parameter int FREQ_W   = 32,
    parameter int DATA_W   = 32
) (
    input wire logic                       clk_in,
    input wire logic                       rstn_in,
    input wire logic [7:0]                 addr_in,
    input wire logic [1:0]                 chan_in,
    input wire logic [DATA_W-1:0]          wdata_in,
    input wire logic                       wr_in,
    input wire logic                       rd_in,
    input wire logic [3:0]                 sync_pin_in,
    input wire logic [DATA_W-1:0]          rdata_out,
    input wire logic                       rdy_out,
    input wire logic [NUM_CHAN-1:0]        chan_run_out,
    input wire logic [NUM_CHAN*FREQ_W-1:0] osc_freq_out
);
    // One clock domain, so clocking and reset are given once
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // Register port answers every access exactly one cycle later
    rdy_pulse_a: assert property ((wr_in || rd_in) |=> rdy_out)
        else $error("ready missing after an access");
    rdy_quiet_a: assert property (!(wr_in || rd_in) |=> !rdy_out)
        else $error("ready without an access");
    // Leaving reset all channels sleep and oscillators are cleared
    reset_sleep_a: assert property ($rose(rstn_in) |-> chan_run_out == '0 && osc_freq_out == '0)
        else $error("channel awake or frequency set after reset");
    // Sleep write reaches the run outputs through the two-flop pipe
    sleep_follow_a: assert property (wr_in && addr_in == sync_ctrl_pkg::ADDR_SLEEP |->
        ##3 chan_run_out == ~$past(wdata_in[3:0], 3))
        else $error("run outputs do not follow the sleep write");
    // Only a sleep write can stop a running channel
    run_fall_a: assert property (|($past(chan_run_out) & ~chan_run_out) |->
        $past(wr_in && addr_in == sync_ctrl_pkg::ADDR_SLEEP, 3))
        else $error("channel stopped without a sleep write");
    // Read data is held between reads
    rdata_hold_a: assert property (!rd_in |=> $stable(rdata_out))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_in && !addr_in[7] && addr_in > 8'h06 |=> rdata_out == '0)
        else $error("unmapped read not zero");
    status_width_a: assert property (rd_in && addr_in == sync_ctrl_pkg::ADDR_STATUS |=>
        rdata_out[DATA_W-1:8] == '0)
        else $error("status upper bits set");
endmodule
bind channel_start_hop_sync sync_monitor #(.NUM_CHAN(NUM_CHAN), .CNT_W(CNT_W), .FREQ_W(FREQ_W),
    .DATA_W(DATA_W)) sync_monitor_i (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .chan_in(chan_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .sync_pin_in(sync_pin_in), .rdata_out(rdata_out), .rdy_out(rdy_out),
    .chan_run_out(chan_run_out), .osc_freq_out(osc_freq_out));
`default_nettype wire

/* sim/host_model.sv */
// Host processor and sync pin sources facing the synchroniser
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic        clk_in,
    input  wire logic        rdy_in,
    input  wire logic [31:0] rdata_in,
    output logic      [7:0]  addr_out,
    output logic      [1:0]  chan_out,
    output logic      [31:0] wdata_out,
    output logic             wr_out,
    output logic             rd_out,
    output logic      [3:0]  pin_out
);
    logic rdy_seen;

    // Idle bus and low sync pins from time zero
    initial begin
        addr_out  = 8'h00;
        chan_out  = 2'h0;
        wdata_out = 32'h0;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        pin_out   = 4'h0;
        rdy_seen  = 1'b0;
    end

    // One strobe per access; address and write data are scrambled after so stale data never helps
    task automatic access(input logic [7:0] a, input logic [1:0] c, input logic [31:0] d,
                          input logic rd, output logic [31:0] q);
        @(negedge clk_in);
        addr_out  = a;
        chan_out  = c;
        wdata_out = d;
        wr_out    = !rd;
        rd_out    = rd;
        @(negedge clk_in);
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        q         = rdata_in;
        rdy_seen  = rdy_in;
        addr_out  = ~a;
        wdata_out = ~d;
    endtask

    // Single-cycle high on one pin, sampled by exactly one rising edge
    task automatic pin_pulse(input int p);
        @(negedge clk_in);
        pin_out[p] = 1'b1;
        @(negedge clk_in);
        pin_out[p] = 1'b0;
    endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking testbench for the channel start and hop synchroniser
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic         clk_in;
    logic         rstn_in;
    logic [7:0]   addr_in;
    logic [1:0]   chan_in;
    logic [31:0]  wdata_in;
    logic         wr_in;
    logic         rd_in;
    logic [3:0]   sync_pin_in;
    logic [31:0]  rdata_out;
    logic         rdy_out;
    logic [3:0]   chan_run_out;
    logic [127:0] osc_freq_out;
    logic [31:0]  q;
    int           err_total = 0;
    int           checked = 0;

    channel_start_hop_sync channel_start_hop_sync_i (.clk_in(clk_in), .rstn_in(rstn_in),
        .addr_in(addr_in), .chan_in(chan_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .sync_pin_in(sync_pin_in), .rdata_out(rdata_out), .rdy_out(rdy_out),
        .chan_run_out(chan_run_out), .osc_freq_out(osc_freq_out));
    host_model host_model_i (.clk_in(clk_in), .rdy_in(rdy_out), .rdata_in(rdata_out),
        .addr_out(addr_in), .chan_out(chan_in), .wdata_out(wdata_in), .wr_out(wr_in),
        .rd_out(rd_in), .pin_out(sync_pin_in));

    // 20 MHz master clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk_run(input logic [3:0] e);
        chk({28'h0, chan_run_out}, {28'h0, e});
    endtask
    task automatic chk_freq(input int c, input logic [31:0] e);
        chk(osc_freq_out[32*c +: 32], e);
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [1:0] c, input logic [31:0] d);
        host_model_i.access(a, c, d, 1'b0, q);
        chk({31'h0, host_model_i.rdy_seen}, 32'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] c, input logic [31:0] e);
        host_model_i.access(a, c, 32'h0, 1'b1, q);
        chk(q, e);
    endtask

    task automatic s_reset;
        chk_run(4'h0);
        rd(sync_ctrl_pkg::ADDR_SLEEP, 0, 32'hf);
        rd(8'h10, 0, 32'h0);
    endtask
    // Plain start: count of one, then sleep cleared by the host
    task automatic s_nosync;
        wr(sync_ctrl_pkg::ADDR_START_CNT, 1, 32'h1);
        wr(sync_ctrl_pkg::ADDR_SLEEP, 0, 32'hd);
        step(1);
        chk_run(4'h0);
        step(1);
        chk_run(4'h2);
        wr(sync_ctrl_pkg::ADDR_SLEEP, 0, 32'hf);
        step(2);
        chk_run(4'h0);
    endtask
    task automatic s_soft_start;
        wr(sync_ctrl_pkg::ADDR_START_CNT, 0, 32'h3);
        wr(sync_ctrl_pkg::ADDR_START_CNT, 2, 32'h3);
        wr(sync_ctrl_pkg::ADDR_SOFT_CTRL, 0, 32'h15);
        step(8);
        chk_run(4'h0);
        step(1);
        chk_run(4'h5);
        rd(sync_ctrl_pkg::ADDR_SLEEP, 0, 32'ha);
        rd(sync_ctrl_pkg::ADDR_STATUS, 0, 32'h0);
        step(20);
        chk_run(4'h5);
        wr(sync_ctrl_pkg::ADDR_SLEEP, 0, 32'hf);
        step(2);
    endtask
    // Two channels share pin C; a pulse on B must start nothing
    task automatic s_pin_start;
        wr(sync_ctrl_pkg::ADDR_PIN_SEL, 3, 32'h2);
        wr(sync_ctrl_pkg::ADDR_PIN_SEL, 1, 32'h2);
        wr(sync_ctrl_pkg::ADDR_START_CNT, 3, 32'h2);
        wr(sync_ctrl_pkg::ADDR_START_CNT, 1, 32'h4);
        wr(sync_ctrl_pkg::ADDR_PIN_CTRL, 0, 32'h14);
        rd(sync_ctrl_pkg::ADDR_PIN_SEL, 3, 32'h2);
        rd(sync_ctrl_pkg::ADDR_START_CNT, 1, 32'h4);
        host_model_i.pin_pulse(1);
        step(10);
        chk_run(4'h0);
        host_model_i.pin_pulse(2);
        step(3);
        chk_run(4'h0);
        step(1);
        chk_run(4'h8);
        step(1);
        chk_run(4'h8);
        step(1);
        chk_run(4'ha);
        wr(sync_ctrl_pkg::ADDR_PIN_CTRL, 0, 32'h0);
        wr(sync_ctrl_pkg::ADDR_SLEEP, 0, 32'hf);
        step(2);
    endtask
    task automatic s_freq_imm;
        wr(sync_ctrl_pkg::ADDR_FREQ_CNT, 2, 32'h0);
        wr(sync_ctrl_pkg::ADDR_FREQ, 2, 32'h12345678);
        step(3);
        chk_freq(2, 32'h0);
        step(1);
        chk_freq(2, 32'h12345678);
    endtask
    task automatic s_hop_soft;
        wr(sync_ctrl_pkg::ADDR_FREQ_CNT, 2, 32'h3);
        wr(sync_ctrl_pkg::ADDR_FREQ, 2, 32'h0badcafe);
        rd(sync_ctrl_pkg::ADDR_FREQ_CNT, 2, 32'h3);
        rd(sync_ctrl_pkg::ADDR_FREQ, 2, 32'h0badcafe);
        step(4);
        chk_freq(2, 32'h12345678);
        wr(sync_ctrl_pkg::ADDR_SOFT_CTRL, 0, 32'h24);
        step(2);
        rd(sync_ctrl_pkg::ADDR_STATUS, 0, 32'h40);
        step(5);
        chk_freq(2, 32'h12345678);
        step(1);
        chk_freq(2, 32'h0badcafe);
        rd(sync_ctrl_pkg::ADDR_STATUS, 0, 32'h0);
        rd(sync_ctrl_pkg::ADDR_SOFT_CTRL, 0, 32'h24);
    endtask
    task automatic s_hop_pin;
        wr(sync_ctrl_pkg::ADDR_PIN_SEL, 0, 32'h0);
        wr(sync_ctrl_pkg::ADDR_FREQ_CNT, 0, 32'h2);
        wr(sync_ctrl_pkg::ADDR_FREQ, 0, 32'h55aa55aa);
        wr(sync_ctrl_pkg::ADDR_PIN_CTRL, 0, 32'h21);
        host_model_i.pin_pulse(0);
        step(5);
        chk_freq(0, 32'h0);
        step(1);
        chk_freq(0, 32'h55aa55aa);
        chk_freq(2, 32'h0badcafe);
        rd(sync_ctrl_pkg::ADDR_PIN_CTRL, 0, 32'h21);
        wr(sync_ctrl_pkg::ADDR_PIN_CTRL, 0, 32'h0);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence after five reset cycles
    initial begin
        rstn_in = 1'b0;
        step(5);
        rstn_in = 1'b1;
        s_reset();
        s_nosync();
        s_soft_start();
        s_pin_start();
        s_freq_imm();
        s_hop_soft();
        s_hop_pin();
        wrap_up();
    end

    // Watchdog well beyond the roughly 160 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
